// ---- design/tcp_pkg.sv ----
// Shared constants and types for the timer carrier PWM generator
package tcp_pkg;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_PERIOD   = 8'h04;
   localparam logic [7:0]  OFS_DUTY     = 8'h08;
   localparam logic [7:0]  OFS_CARRIER  = 8'h0C;
   localparam logic [7:0]  OFS_STATUS   = 8'h10;
   localparam int          CTRL_RUN     = 0;
   localparam int          CTRL_MODE    = 1;
   localparam int          CTRL_CKS_LO  = 2;
   localparam int          CAR_ACTIVE   = 0;
   localparam int          CAR_STAGING  = 1;
   localparam int          CAR_REMOTE   = 2;
   localparam int          ST_CNT_LO    = 0;
   localparam int          ST_DUTY_LO   = 8;
   localparam int          ST_WAVE      = 16;
   localparam int          ST_CARRIER   = 17;
   localparam int          ST_SEL       = 18;
   localparam logic [7:0]  COUNT_ZERO   = 8'h00;
   localparam logic [7:0]  PERIOD_RST   = 8'hFF;
   localparam logic [7:0]  DUTY_RST     = 8'h00;
   localparam logic [1:0]  DUTY_XFER_CLKS = 2'h3;
   localparam logic [1:0]  ENV_XFER_CLKS  = 2'h2;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

   typedef struct packed {
      logic [2:0] count_clock_select;
      logic       carrier_mode;
      logic       timer_run_enable;
   } tcp_cfg_s;

   typedef struct packed {
      logic remote_output_enable;
      logic envelope_level_staging;
   } tcp_car_s;
endpackage

// ---- design/tcp_env_sync.sv ----
// Envelope event synchroniser and staging-to-active level transfer
`timescale 1ns/1ps
module tcp_env_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic count_tick,
   input  wire logic envelope_timer_event,
   input  wire logic envelope_level_staging,
   output logic      envelope_sync_pulse,
   output logic      envelope_level_active
);
   logic       event_q;
   logic       event_seen;
   logic       event_rise;
   logic       xfer_busy;
   logic [1:0] xfer_cnt;

   assign event_rise = envelope_timer_event & ~event_q;

   // RULE11 sample event every clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_q <= 1'b0;
      end else begin
         event_q <= envelope_timer_event;
      end
   end

   // RULE11 hold rise until count clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_seen <= 1'b0;
      end else if (count_tick) begin
         event_seen <= 1'b0;
      end else if (event_rise) begin
         event_seen <= 1'b1;
      end
   end

   // RULE11 rising edge gives sync pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         envelope_sync_pulse <= 1'b0;
      end else if (count_tick) begin
         envelope_sync_pulse <= event_rise | event_seen;
      end
   end

   // RULE12 copy on second count clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xfer_busy <= 1'b0;
         xfer_cnt  <= 2'h0;
      end else if (count_tick) begin
         if (envelope_sync_pulse && !xfer_busy) begin
            xfer_busy <= 1'b1;
            xfer_cnt  <= 2'h1;
         end else if (xfer_busy) begin
            if (xfer_cnt == tcp_pkg::ENV_XFER_CLKS - 2'h1) begin
               xfer_busy <= 1'b0;
            end
            xfer_cnt <= xfer_cnt + 2'h1;
         end
      end
   end

   // RULE10 active level driven only by transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         envelope_level_active <= 1'b0;
      end else if (count_tick && xfer_busy && xfer_cnt == tcp_pkg::ENV_XFER_CLKS - 2'h1) begin
         envelope_level_active <= envelope_level_staging;
      end
   end
endmodule

// ---- design/tcp_timer.sv ----
// PWM timer with carrier generator mode and AHB-Lite register slave
// Behaviour
// RULE1: mask first count clock, output default
// RULE2: duty write latched, moved on old match
// RULE3: transfer needs three count clocks after write
// RULE4: period match clears, toggles, raises interrupt
// RULE5: duty match only toggles the wave
// RULE6: stopping returns interrupt and wave default
// RULE7: carrier mode only on instance one
// RULE8: software must not rewrite low width running
// RULE9: carrier pin follows active and remote bits
// RULE10: staging bit writable, active bit read only
// RULE11: envelope event synchronised into sync pulse
// RULE12: copy on second clock after sync
// RULE13: software spaces staging writes two clocks
// RULE14: software rewrites staging in sync handler
// RULE15: carrier counts low then high, swaps
// RULE16: period N+M+2, high phase M+1
// RULE17: software rewrites high width before restart
// RULE18: count clock over six times envelope clock
// RULE19: software keeps widths within 01H..FFH
// RULE20: software sets remote enable before run
// RULE21: pulses begin at next carrier rising edge
// RULE22: high carrier phase never truncated
// RULE23: software keeps remote enable fixed running
// RULE24: 8-bit up-counter, holds zero when stopped
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module tcp_timer #(
   parameter bit CARRIER_CAPABLE = 1'b1,
   parameter int CNT_W           = 8,
   parameter int PRESC_W         = 7
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        envelope_timer_event,
   output logic             envelope_sync_pulse,
   output logic             timer_wave_out,
   output logic             carrier_out_pin,
   output logic             compare_match_irq
);
   if (CNT_W != 8) begin : g_chk_w
      $error("CNT_W must be 8");
   end
   if (PRESC_W < 1 || PRESC_W > 7) begin : g_chk_p
      $error("PRESC_W must be 1 to 7");
   end

   typedef enum logic [1:0] {
      TCP_CMP_FIRST  = 2'b01,
      TCP_CMP_SECOND = 2'b10
   } tcp_sel_e;

   tcp_pkg::tcp_cfg_s  cfg;
   tcp_pkg::tcp_car_s  car;
   tcp_sel_e           cmp_sel;
   logic [CNT_W-1:0]   period_compare;
   logic [CNT_W-1:0]   duty_compare;
   logic [CNT_W-1:0]   duty_latch;
   logic               duty_pending;
   logic [1:0]         duty_age;
   logic [CNT_W-1:0]   count;
   logic [PRESC_W-1:0] presc;
   logic               count_tick;
   logic               start_mask;
   logic               wave;
   logic               carrier_gate;
   logic               envelope_level_active;
   logic               run;
   logic               carrier_on;
   logic               match_first;
   logic               match_second;
   logic               duty_xfer;
   logic               wr_pend;
   logic [7:0]         wr_addr;
   logic               rd_pend;
   logic [7:0]         rd_addr;
   logic               addr_take;
   logic               duty_wr;

   function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] sel);
      logic [PRESC_W:0] one_hot;
      one_hot    = '0;
      one_hot[0] = 1'b1;
      one_hot    = one_hot << sel;
      return PRESC_W'(one_hot - 1'b1);
   endfunction

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   assign run        = cfg.timer_run_enable;
   // RULE7 carrier only where instance allows it
   assign carrier_on = CARRIER_CAPABLE & cfg.carrier_mode;
   assign addr_take  = hsel & hready & htrans[1];
   assign hreadyout  = ~rd_pend;
   assign hresp      = 1'b0;
   assign duty_wr    = wr_pend & reg_hit(wr_addr, tcp_pkg::OFS_DUTY);

   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else begin
         wr_pend <= addr_take & hwrite;
         rd_pend <= addr_take & ~hwrite;
         if (addr_take) begin
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
         end
      end
   end

   // Read data registered after one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= tcp_pkg::RDATA_ZERO;
      end else if (rd_pend) begin
         hrdata <= tcp_pkg::RDATA_ZERO;
         if (reg_hit(rd_addr, tcp_pkg::OFS_CTRL)) begin
            hrdata[tcp_pkg::CTRL_CKS_LO+2:0] <= cfg;
         end else if (reg_hit(rd_addr, tcp_pkg::OFS_PERIOD)) begin
            hrdata[CNT_W-1:0] <= period_compare;
         end else if (reg_hit(rd_addr, tcp_pkg::OFS_DUTY)) begin
            hrdata[CNT_W-1:0] <= duty_latch;
         end else if (reg_hit(rd_addr, tcp_pkg::OFS_CARRIER)) begin
            hrdata[tcp_pkg::CAR_REMOTE:tcp_pkg::CAR_STAGING] <= car;
            hrdata[tcp_pkg::CAR_ACTIVE]                      <= envelope_level_active;
         end else if (reg_hit(rd_addr, tcp_pkg::OFS_STATUS)) begin
            hrdata[tcp_pkg::ST_CNT_LO+CNT_W-1:tcp_pkg::ST_CNT_LO]   <= count;
            hrdata[tcp_pkg::ST_DUTY_LO+CNT_W-1:tcp_pkg::ST_DUTY_LO] <= duty_compare;
            hrdata[tcp_pkg::ST_WAVE]    <= wave;
            hrdata[tcp_pkg::ST_CARRIER] <= carrier_out_pin;
            hrdata[tcp_pkg::ST_SEL]     <= (cmp_sel == TCP_CMP_SECOND);
         end
      end
   end

   // Control and compare registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg            <= '0;
         car            <= '0;
         period_compare <= tcp_pkg::PERIOD_RST;
      end else if (wr_pend) begin
         if (reg_hit(wr_addr, tcp_pkg::OFS_CTRL)) begin
            cfg <= hwdata[tcp_pkg::CTRL_CKS_LO+2:0];
         end
         if (reg_hit(wr_addr, tcp_pkg::OFS_PERIOD)) begin
            period_compare <= hwdata[CNT_W-1:0];
         end
         // RULE10 staging bit writable, active not
         if (reg_hit(wr_addr, tcp_pkg::OFS_CARRIER)) begin
            car <= hwdata[tcp_pkg::CAR_REMOTE:tcp_pkg::CAR_STAGING];
         end
      end
   end

   // Count clock prescaler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc <= '0;
      end else begin
         presc <= presc + 1'b1;
      end
   end
   assign count_tick = (presc & presc_mask(cfg.count_clock_select)) ==
                       presc_mask(cfg.count_clock_select);

   assign match_first  = (cmp_sel == TCP_CMP_FIRST) && (count == period_compare);
   assign match_second = (cmp_sel == TCP_CMP_SECOND) && (count == duty_compare);
   // RULE3 transfer only when latch old enough
   assign duty_xfer    = match_second & duty_pending & (duty_age >= tcp_pkg::DUTY_XFER_CLKS);

   // RULE2 duty write held in latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_latch   <= tcp_pkg::DUTY_RST;
         duty_pending <= 1'b0;
         duty_age     <= 2'h0;
      end else if (duty_wr) begin
         duty_latch   <= hwdata[CNT_W-1:0];
         duty_pending <= run;
         duty_age     <= 2'h0;
      end else begin
         if (count_tick && run && !start_mask && duty_xfer) begin
            duty_pending <= 1'b0;
         end
         // RULE3 age counted in count clocks
         if (count_tick && duty_age != tcp_pkg::DUTY_XFER_CLKS) begin
            duty_age <= duty_age + 2'h1;
         end
      end
   end

   // RULE2 active duty updated on old match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_compare <= tcp_pkg::DUTY_RST;
      end else if (duty_wr && !run) begin
         duty_compare <= hwdata[CNT_W-1:0];
      end else if (count_tick && run && !start_mask && duty_xfer) begin
         duty_compare <= duty_latch;
      end
   end

   // RULE1 first count clock masked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_mask <= 1'b1;
      end else if (!run) begin
         start_mask <= 1'b1;
      end else if (count_tick) begin
         start_mask <= 1'b0;
      end
   end

   // RULE24 counter holds zero when stopped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count   <= tcp_pkg::COUNT_ZERO;
         cmp_sel <= TCP_CMP_FIRST;
      end else if (!run) begin
         count   <= tcp_pkg::COUNT_ZERO;
         cmp_sel <= TCP_CMP_FIRST;
      end else if (count_tick && !start_mask) begin
         unique case (cmp_sel)
            TCP_CMP_FIRST: begin
               // RULE4 period or low width match clears
               if (match_first) begin
                  count   <= tcp_pkg::COUNT_ZERO;
                  cmp_sel <= TCP_CMP_SECOND;
               end else begin
                  count <= count + 1'b1;
               end
            end
            TCP_CMP_SECOND: begin
               if (match_second) begin
                  cmp_sel <= TCP_CMP_FIRST;
               end
               // RULE15 carrier clears on high width match
               if (match_second && carrier_on) begin
                  count <= tcp_pkg::COUNT_ZERO;
               end else begin
                  // RULE5 duty match does not clear
                  count <= count + 1'b1;
               end
            end
            default: begin
               count   <= tcp_pkg::COUNT_ZERO;
               cmp_sel <= TCP_CMP_FIRST;
            end
         endcase
      end
   end

   // RULE6 stop returns wave to default
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave <= 1'b0;
      end else if (!run) begin
         wave <= 1'b0;
      end else if (count_tick && !start_mask && (match_first || match_second)) begin
         // RULE16 carrier toggles give N+1 low, M+1 high; PWM mode gives M+1 high, N-M low
         wave <= ~wave;
      end
   end

   // RULE6 stop returns interrupt to default
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_match_irq <= 1'b0;
      end else if (!run) begin
         compare_match_irq <= 1'b0;
      end else begin
         // RULE4 interrupt on period match
         // RULE15 carrier interrupts on every match
         compare_match_irq <= count_tick && !start_mask &&
                              (match_first || (match_second && carrier_on));
      end
   end

   // RULE21 gate opens at carrier rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_gate <= 1'b0;
      end else if (!run || !carrier_on) begin
         carrier_gate <= 1'b0;
      end else if (count_tick && !start_mask && (match_first || match_second)) begin
         if (!wave) begin
            carrier_gate <= envelope_level_active;
         end else begin
            // RULE22 gate closes only at high phase end
            carrier_gate <= carrier_gate & envelope_level_active;
         end
      end
   end

   // PWM wave pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_wave_out <= 1'b0;
      end else begin
         timer_wave_out <= wave & ~carrier_on;
      end
   end

   // RULE9 carrier pin from active level and remote enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_out_pin <= 1'b0;
      end else if (!carrier_on) begin
         carrier_out_pin <= 1'b0;
      end else if (car.remote_output_enable) begin
         carrier_out_pin <= carrier_gate & wave;
      end else begin
         carrier_out_pin <= envelope_level_active;
      end
   end

   // RULE11 envelope synchroniser and level transfer
   tcp_env_sync u_env_sync (
      .hclk                   (hclk),
      .hresetn                (hresetn),
      .count_tick             (count_tick),
      .envelope_timer_event   (envelope_timer_event),
      .envelope_level_staging (car.envelope_level_staging),
      .envelope_sync_pulse    (envelope_sync_pulse),
      .envelope_level_active  (envelope_level_active)
   );
endmodule

// ---- verif/tcp_timer_monitor.sv ----
// Port checker for the timer carrier PWM generator
`timescale 1ns/1ps
module tcp_timer_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        envelope_timer_event,
   input wire logic        envelope_sync_pulse,
   input wire logic        timer_wave_out,
   input wire logic        carrier_out_pin,
   input wire logic        compare_match_irq
);
   logic       wr_q;
   logic       rd_q;
   logic [4:0] ctl;
   logic [1:0] settle;
   logic       run;
   logic       car;
   logic       fast;
   logic       irq;
   assign run  = ctl[0];
   assign car  = ctl[1];
   assign fast = run && car && (ctl[4:2] == 3'h0);
   assign irq  = compare_match_irq;
   // Follows control writes seen on the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == tcp_pkg::OFS_CTRL);
         rd_q <= hsel && hready && htrans[1] && !hwrite;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl    <= 5'h00;
         settle <= 2'h3;
      end else if (wr_q) begin
         ctl    <= hwdata[4:0];
         settle <= 2'h0;
      end else if (settle != 2'h3) begin
         settle <= settle + 2'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_start_masked: assert property (
      wr_q && hwdata[0] && !hwdata[1] && !run |-> ##1 !timer_wave_out [*3])
      else $error("wave moved too soon after start");
   chk_period_irq: assert property (
      run && !car && $rose(timer_wave_out) |-> $past(irq))
      else $error("wave rose without interrupt");
   chk_irq_single: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   chk_duty_quiet: assert property (
      run && !car && $fell(timer_wave_out) |-> !$past(irq))
      else $error("interrupt at duty match");
   chk_stop_default: assert property (
      wr_q && !hwdata[0] && run |-> ##[1:3] (!timer_wave_out && !irq && !carrier_out_pin))
      else $error("outputs not default after stop");
   chk_mode_pins: assert property (
      settle == 2'h3 |-> (car ? !timer_wave_out : !carrier_out_pin))
      else $error("pin of unused mode active");
   chk_sync_prompt: assert property (
      fast && $rose(envelope_timer_event) |-> ##[1:3] envelope_sync_pulse)
      else $error("no sync pulse after event");
   chk_high_kept: assert property (
      $rose(carrier_out_pin) && run |=> carrier_out_pin || !run)
      else $error("carrier high phase cut short");
   chk_read_wait: assert property (rd_q |-> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule
bind tcp_timer tcp_timer_monitor u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .envelope_timer_event(envelope_timer_event), .envelope_sync_pulse(envelope_sync_pulse),
   .timer_wave_out(timer_wave_out), .carrier_out_pin(carrier_out_pin),
   .compare_match_irq(compare_match_irq)
);

// ---- verif/tcp_env_model.sv ----
// Companion envelope timer model making the event pulses
`timescale 1ns/1ps
module tcp_env_model #(
   parameter int PERIOD = 40
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic enable,
   output logic      envelope_timer_event
);
   int cnt;
   // event far slower than count clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt                  <= 0;
         envelope_timer_event <= 1'b0;
      end else begin
         cnt                  <= (enable && cnt < PERIOD - 1) ? cnt + 1 : 0;
         envelope_timer_event <= enable && (cnt == PERIOD - 1);
      end
   end
endmodule

// ---- verif/timer_carrier_pwm_generator_bench.sv ----
// Self-checking bench for the timer carrier PWM generator
`timescale 1ns/1ps
module timer_carrier_pwm_generator_bench;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } tcp_row_s;
   localparam tcp_row_s ROWS [6] = '{
      '{tcp_pkg::OFS_PERIOD, 32'h5A, 32'h5A}, '{tcp_pkg::OFS_DUTY, 32'h33, 32'h33},
      '{tcp_pkg::OFS_CARRIER, 32'h6, 32'h6}, '{tcp_pkg::OFS_CARRIER, 32'h7, 32'h6},
      '{tcp_pkg::OFS_CTRL, 32'h1C, 32'h1C}, '{8'h14, 32'hFFFF_FFFF, 32'h0}};
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        env_run;
   logic        ev;
   logic        sync;
   logic        wave;
   logic        pin;
   logic        irq;
   logic [31:0] r;
   int          irqs;
   int          fails;
   int          comparisons;
   int          hi;
   int          lo;
   tcp_timer DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .envelope_timer_event(ev),
      .envelope_sync_pulse(sync), .timer_wave_out(wave), .carrier_out_pin(pin),
      .compare_match_irq(irq));
   tcp_env_model u_env (.hclk(hclk), .hresetn(hresetn), .enable(env_run),
      .envelope_timer_event(ev));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= tcp_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic sync_wait;
      do @(posedge hclk); while (sync !== 1'b1);
   endtask
   task automatic span(input bit c);
      hi = 0;
      lo = 0;
      irqs = 0;
      while ((c ? pin : wave) !== 1'b0) @(posedge hclk);
      while ((c ? pin : wave) !== 1'b1) @(posedge hclk);
      while ((c ? pin : wave) === 1'b1) begin
         @(posedge hclk);
         hi++;
         irqs += int'(irq);
      end
      while ((c ? pin : wave) === 1'b0) begin
         @(posedge hclk);
         lo++;
         irqs += int'(irq);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      close_out();
   end
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, env_run, hresetn} = '0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ROWS[i]) begin
         xfer(ROWS[i].a, 1'b1, ROWS[i].d);
         xfer(ROWS[i].a, 1'b0, 32'h0);
         check(r, ROWS[i].e);
      end
      @(posedge hclk) hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(tcp_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(r, 32'h0);
      xfer(tcp_pkg::OFS_PERIOD, 1'b0, 32'h0);
      check(r, {24'h0, tcp_pkg::PERIOD_RST});
      xfer(tcp_pkg::OFS_DUTY, 1'b0, 32'h0);
      check(r, {24'h0, tcp_pkg::DUTY_RST});
      xfer(tcp_pkg::OFS_CARRIER, 1'b0, 32'h0);
      check(r, 32'h0);
      xfer(tcp_pkg::OFS_PERIOD, 1'b1, 32'h9);
      xfer(tcp_pkg::OFS_DUTY, 1'b1, 32'h3);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h1);
      span(1'b0);
      check(hi, 4);
      check(hi + lo, 10);
      check(irqs, 1);
      xfer(tcp_pkg::OFS_DUTY, 1'b1, 32'h6);
      span(1'b0);
      span(1'b0);
      check(hi, 7);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h0);
      xfer(tcp_pkg::OFS_DUTY, 1'b1, 32'h3);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h5);
      span(1'b0);
      check(hi, 8);
      check(hi + lo, 20);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h0);
      xfer(tcp_pkg::OFS_STATUS, 1'b0, 32'h0);
      check(r & 32'h0003_00FF, 32'h0);
      xfer(tcp_pkg::OFS_PERIOD, 1'b1, 32'h2);
      xfer(tcp_pkg::OFS_DUTY, 1'b1, 32'h4);
      xfer(tcp_pkg::OFS_CARRIER, 1'b1, 32'h6);
      env_run <= 1'b1;
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h3);
      sync_wait();
      repeat (4) @(posedge hclk);
      xfer(tcp_pkg::OFS_CARRIER, 1'b0, 32'h0);
      check(r, 32'h7);
      span(1'b1);
      check(hi, 5);
      check(lo, 3);
      check(irqs, 2);
      sync_wait();
      xfer(tcp_pkg::OFS_CARRIER, 1'b1, 32'h4);
      sync_wait();
      repeat (8) @(posedge hclk);
      repeat (10) @(posedge hclk) check(pin, 1'b0);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h0);
      xfer(tcp_pkg::OFS_DUTY, 1'b1, 32'h4);
      xfer(tcp_pkg::OFS_CARRIER, 1'b1, 32'h2);
      xfer(tcp_pkg::OFS_CTRL, 1'b1, 32'h3);
      sync_wait();
      repeat (8) @(posedge hclk);
      repeat (10) @(posedge hclk) check(pin, 1'b1);
      close_out();
   end
endmodule
